// ### core/mmt_regs_regs.vh
`ifndef MMT_REGS_REGS_VH
`define MMT_REGS_REGS_VH
// register word offsets (byte addresses)
`define MMT_OFS_START_A   8'h00
`define MMT_OFS_START_B   8'h04
`define MMT_OFS_IRQ_STAT  8'h08
`define MMT_OFS_IRQ_MASK  8'h0c
`define MMT_OFS_MODE_A    8'h10
`define MMT_OFS_OS_TRIG   8'h30
`define MMT_OFS_COUNT_A   8'h40
`define MMT_OFS_MODE_B    8'h60
`define MMT_OFS_COUNT_B   8'h80
// channel counts
`define MMT_NUM_A         5
`define MMT_NUM_B         6
// timer_a_mode_register fields
`define MMT_AM_MODE_LSB   0
`define MMT_AM_UP         2
`define MMT_AM_EXT        3
`define MMT_AM_WIDTH      4
// timer A operating modes
`define MMT_MODE_TMR      2'h0
`define MMT_MODE_EVT      2'h1
`define MMT_MODE_OS       2'h2
`define MMT_MODE_PWM      2'h3
// timer_b_mode_register: bit 0 selects event counting
`define MMT_BM_EVT        0
// count-start register split: B0..B1 share register A
`define MMT_SA_B_LSB      5
`define MMT_SB_B_LSB      2
// reset values and special readbacks
`define MMT_RST_CNT       16'h0000
`define MMT_RD_RELOAD     16'hffff
`define MMT_RD_OVF        16'h0000
// internal count source divide ratio in mclk cycles
`define MMT_PRESCALE      8
`endif

// ### core/mmt_timer.v
// Contract
// - after reset all channels idle; a channel counts only once its run bit is 1
// - A timer count readable while running; reload read gives ffff; stopped write reads back
// - A event count reads ffff at underflow reload and 0000 at overflow
// - one-shot stop halts counter, copies reload into counter, output low
// - one-shot stop sets interrupt flag one clock later
// - one-shot output follows count source; external trigger lags at most one tick
// - selecting one-shot from timer or event mode sets interrupt flag
// - retrigger while running: count down once, reload, keep counting
// - selecting PWM from timer or event mode sets interrupt flag
// - PWM stop while output high: stop, output low, set interrupt flag
// - PWM stop while output low: stop, output and flag unchanged
// - B count readable while running; reload read gives ffff; stopped write reads back
// - B run bits held across the two count-start registers; 1 starts
//
// Decided for this implementation: the placing of the registers and the APB register port.
`include "mmt_regs_regs.vh"
module mmt_timer #(
	parameter PRESCALE = `MMT_PRESCALE
)(
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [4:0]  event_in_a,
	input  wire [4:0]  trigger_input_a,
	input  wire [5:0]  event_in_b,
	output wire [4:0]  pulse_output_a,
	output wire        irq
);
	localparam NA = `MMT_NUM_A;
	localparam NB = `MMT_NUM_B;
	localparam NI = NA + NB;

	reg [15:0] a_cnt_ff [0:NA-1];
	reg [15:0] a_rel_ff [0:NA-1];
	reg [3:0]  a_mode_ff [0:NA-1];
	reg [15:0] b_cnt_ff [0:NB-1];
	reg [15:0] b_rel_ff [0:NB-1];
	reg        b_mode_ff [0:NB-1];
	reg [NA-1:0] run_bit_a;
	reg [NB-1:0] run_bit_b;
	reg [NA-1:0] out_ff;
	reg [NA-1:0] os_act_ff;
	reg [NA-1:0] os_trg_ff;
	reg [NA-1:0] os_retrig_ff;
	reg [NA-1:0] os_stop_ff;
	reg [NA-1:0] ev_a_ff;
	reg [NA-1:0] tg_a_ff;
	reg [NB-1:0] ev_b_ff;
	reg [NI-1:0] stat_ff;
	reg [NI-1:0] mask_ff;
	reg [31:0]   prdata_ff;
	reg [7:0]    div_ff;
	reg          tick_ff;

	reg [NA-1:0] nxt_run_a;
	reg [NB-1:0] nxt_run_b;
	reg [NA-1:0] a_ev;
	reg [NA-1:0] a_rld;
	reg [NA-1:0] a_ovf;
	reg [NA-1:0] a_trg;
	reg [NB-1:0] b_ev;
	reg [NB-1:0] b_rld;
	reg [NI-1:0] irq_set;
	reg [31:0]   rd_val;
	reg          rd_hit;
	reg [1:0]    m;
	reg [1:0]    nm;
	integer      i;

	wire       wr  = psel & penable & pwrite;
	wire       rd  = psel & ~penable & ~pwrite;
	wire [5:0] idx = paddr[7:2];

	// word index of a register group base
	function [5:0] fn_idx;
		input [7:0] ofs;
		begin
			fn_idx = ofs[7:2];
		end
	endfunction

	// wrapping decrement kept at counter width (0000 gives ffff)
	function [15:0] fn_dec;
		input [15:0] v;
		begin
			fn_dec = v - 16'h0001;
		end
	endfunction

	// zero-wait slave: every access completes in one access cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~rd_hit;
	assign prdata  = prdata_ff;
	assign pulse_output_a = out_ff;
	assign irq     = |(stat_ff & mask_ff);

	// run bits after a start-register write; B bits span both registers
	always @*
	begin
		nxt_run_a = run_bit_a;
		nxt_run_b = run_bit_b;
		if (wr && idx == fn_idx(`MMT_OFS_START_A))
		begin
			nxt_run_a = pwdata[NA-1:0];
			nxt_run_b[1:0] = pwdata[`MMT_SA_B_LSB +: 2];
		end
		if (wr && idx == fn_idx(`MMT_OFS_START_B))
			nxt_run_b[NB-1:2] = pwdata[`MMT_SB_B_LSB +: 4];
	end

	// per-channel count events, reloads and interrupt sources
	// own loop index, so no process shares a driver on it
	always @*
	begin : ev_comb
		integer i;
		i = 0;
		irq_set = {NI{1'b0}};
		m  = 2'h0;
		nm = 2'h0;
		for (i = 0; i < NA; i = i + 1)
		begin
			m = a_mode_ff[i][1:0];
			nm = pwdata[1:0];
			a_ev[i] = run_bit_a[i] & ((m == `MMT_MODE_EVT) ?
				(event_in_a[i] & ~ev_a_ff[i]) : tick_ff);
			a_trg[i] = (wr && idx == fn_idx(`MMT_OFS_OS_TRIG) && pwdata[i]) |
				(a_mode_ff[i][`MMT_AM_EXT] & trigger_input_a[i] & ~tg_a_ff[i]);
			a_ovf[i] = a_ev[i] & (m == `MMT_MODE_EVT) &
				a_mode_ff[i][`MMT_AM_UP] & (a_cnt_ff[i] == 16'hffff);
			a_rld[i] = a_ovf[i] | (a_ev[i] & (a_cnt_ff[i] == 16'h0000) &
				((m == `MMT_MODE_TMR) || ((m == `MMT_MODE_EVT) &&
				!a_mode_ff[i][`MMT_AM_UP])));
			irq_set[i] = a_rld[i] | os_stop_ff[i];
			// one-shot expiry and PWM end of high phase
			if (tick_ff && run_bit_a[i] && out_ff[i] &&
				a_cnt_ff[i] == 16'h0000 && !os_retrig_ff[i])
				irq_set[i] = 1'b1;
			// stopping PWM while high raises the flag, low leaves it
			if (m == `MMT_MODE_PWM && run_bit_a[i] && !nxt_run_a[i] &&
				out_ff[i])
				irq_set[i] = 1'b1;
			// entering a pulse mode from a counting mode
			if (wr && idx == fn_idx(`MMT_OFS_MODE_A) + i[5:0] &&
				!m[1] && nm[1])
				irq_set[i] = 1'b1;
		end
		for (i = 0; i < NB; i = i + 1)
		begin
			b_ev[i] = run_bit_b[i] & (b_mode_ff[i] ?
				(event_in_b[i] & ~ev_b_ff[i]) : tick_ff);
			b_rld[i] = b_ev[i] & (b_cnt_ff[i] == 16'h0000);
			irq_set[NA+i] = b_rld[i];
		end
	end

	// read mux; a read that meets a timer- or event-mode reload shows the marker value
	always @*
	begin : rd_comb
		integer i;
		i = 0;
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		if (idx == fn_idx(`MMT_OFS_START_A))
			rd_val = {25'h0, run_bit_b[1:0], run_bit_a};
		else if (idx == fn_idx(`MMT_OFS_START_B))
			rd_val = {26'h0, run_bit_b[NB-1:2], 2'h0};
		else if (idx == fn_idx(`MMT_OFS_IRQ_STAT))
			rd_val = {21'h0, stat_ff};
		else if (idx == fn_idx(`MMT_OFS_IRQ_MASK))
			rd_val = {21'h0, mask_ff};
		else if (idx == fn_idx(`MMT_OFS_OS_TRIG))
			rd_val = 32'h0000_0000;
		else
			rd_hit = 1'b0;
		for (i = 0; i < NA; i = i + 1)
		begin
			if (idx == fn_idx(`MMT_OFS_MODE_A) + i[5:0])
			begin
				rd_val = {28'h0, a_mode_ff[i]};
				rd_hit = 1'b1;
			end
			if (idx == fn_idx(`MMT_OFS_COUNT_A) + i[5:0])
			begin
				rd_hit = 1'b1;
				if (a_ovf[i])
					rd_val = {16'h0, `MMT_RD_OVF};
				else if (a_rld[i])
					rd_val = {16'h0, `MMT_RD_RELOAD};
				else
					rd_val = {16'h0, a_cnt_ff[i]};
			end
		end
		for (i = 0; i < NB; i = i + 1)
		begin
			if (idx == fn_idx(`MMT_OFS_MODE_B) + i[5:0])
			begin
				rd_val = {31'h0, b_mode_ff[i]};
				rd_hit = 1'b1;
			end
			if (idx == fn_idx(`MMT_OFS_COUNT_B) + i[5:0])
			begin
				rd_hit = 1'b1;
				rd_val = {16'h0, b_rld[i] ? `MMT_RD_RELOAD : b_cnt_ff[i]};
			end
		end
	end

	// count source divider, bus registers and interrupt status
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			div_ff    <= 8'h00;
			tick_ff   <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			stat_ff   <= {NI{1'b0}};
			mask_ff   <= {NI{1'b0}};
			run_bit_a <= {NA{1'b0}};
			run_bit_b <= {NB{1'b0}};
		end
		else
		begin
			tick_ff <= (div_ff == PRESCALE - 1);
			div_ff  <= (div_ff == PRESCALE - 1) ? 8'h00 : div_ff + 8'h01;
			if (rd)
				prdata_ff <= rd_val;
			if (wr && idx == fn_idx(`MMT_OFS_IRQ_MASK))
				mask_ff <= pwdata[NI-1:0];
			// a new event beats a simultaneous write-one clear
			if (wr && idx == fn_idx(`MMT_OFS_IRQ_STAT))
				stat_ff <= (stat_ff & ~pwdata[NI-1:0]) | irq_set;
			else
				stat_ff <= stat_ff | irq_set;
			run_bit_a <= nxt_run_a;
			run_bit_b <= nxt_run_b;
		end
	end

	// channel counters
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			out_ff       <= {NA{1'b0}};
			os_act_ff    <= {NA{1'b0}};
			os_trg_ff    <= {NA{1'b0}};
			os_retrig_ff <= {NA{1'b0}};
			os_stop_ff   <= {NA{1'b0}};
			ev_a_ff      <= {NA{1'b0}};
			tg_a_ff      <= {NA{1'b0}};
			ev_b_ff      <= {NB{1'b0}};
			for (i = 0; i < NA; i = i + 1)
			begin
				a_cnt_ff[i]  <= `MMT_RST_CNT;
				a_rel_ff[i]  <= `MMT_RST_CNT;
				a_mode_ff[i] <= 4'h0;
			end
			for (i = 0; i < NB; i = i + 1)
			begin
				b_cnt_ff[i]  <= `MMT_RST_CNT;
				b_rel_ff[i]  <= `MMT_RST_CNT;
				b_mode_ff[i] <= 1'b0;
			end
		end
		else
		begin
			ev_a_ff    <= event_in_a;
			tg_a_ff    <= trigger_input_a;
			ev_b_ff    <= event_in_b;
			os_stop_ff <= {NA{1'b0}};
			for (i = 0; i < NA; i = i + 1)
			begin
				// software stops channel before mode writes
				if (wr && idx == fn_idx(`MMT_OFS_MODE_A) + i[5:0])
					a_mode_ff[i] <= pwdata[3:0];
				if (wr && idx == fn_idx(`MMT_OFS_COUNT_A) + i[5:0])
				begin
					a_rel_ff[i] <= pwdata[15:0];
					if (!run_bit_a[i])
						a_cnt_ff[i] <= pwdata[15:0];
				end
				if (a_trg[i])
					os_trg_ff[i] <= 1'b1;
				if (run_bit_a[i] && !nxt_run_a[i])
				begin
					os_act_ff[i]    <= 1'b0;
					os_trg_ff[i]    <= 1'b0;
					os_retrig_ff[i] <= 1'b0;
					if (a_mode_ff[i][1:0] == `MMT_MODE_OS)
					begin
						a_cnt_ff[i]   <= a_rel_ff[i];
						out_ff[i]     <= 1'b0;
						os_stop_ff[i] <= 1'b1;
					end
					else if (a_mode_ff[i][1:0] == `MMT_MODE_PWM)
						out_ff[i] <= 1'b0;
				end
				else if (!run_bit_a[i] && nxt_run_a[i])
				begin
					a_cnt_ff[i] <= a_rel_ff[i];
					// PWM opens with its high phase
					if (a_mode_ff[i][1:0] == `MMT_MODE_PWM)
						out_ff[i] <= 1'b1;
				end
				else if (!run_bit_a[i])
				begin
					// stopped: hold everything
				end
				else if (a_mode_ff[i][1:1] == 1'b0)
				begin
					if (a_rld[i])
						a_cnt_ff[i] <= a_rel_ff[i];
					else if (a_ev[i] && a_mode_ff[i][`MMT_AM_UP] &&
						a_mode_ff[i][1:0] == `MMT_MODE_EVT)
						a_cnt_ff[i] <= a_cnt_ff[i] + 16'h0001;
					else if (a_ev[i])
						a_cnt_ff[i] <= fn_dec(a_cnt_ff[i]);
				end
				else if (tick_ff)
				begin
					// pulse modes act only on count-source ticks
					if (a_mode_ff[i][1:0] == `MMT_MODE_OS)
					begin
						os_trg_ff[i] <= a_trg[i];
						if (os_retrig_ff[i])
						begin
							a_cnt_ff[i]     <= a_rel_ff[i];
							os_retrig_ff[i] <= 1'b0;
						end
						else if (os_act_ff[i] && a_cnt_ff[i] == 16'h0000)
						begin
							os_act_ff[i] <= 1'b0;
							out_ff[i]    <= 1'b0;
							a_cnt_ff[i]  <= a_rel_ff[i];
						end
						else if (os_act_ff[i])
						begin
							a_cnt_ff[i]     <= fn_dec(a_cnt_ff[i]);
							os_retrig_ff[i] <= os_trg_ff[i];
						end
						else if (os_trg_ff[i])
						begin
							os_act_ff[i] <= 1'b1;
							out_ff[i]    <= 1'b1;
						end
					end
					else if (a_cnt_ff[i] == 16'h0000)
					begin
						// high phase lasts reload+1 ticks, low phase counts down from the inverted reload
						out_ff[i]   <= ~out_ff[i];
						a_cnt_ff[i] <= out_ff[i] ? ~a_rel_ff[i] : a_rel_ff[i];
					end
					else
						a_cnt_ff[i] <= fn_dec(a_cnt_ff[i]);
				end
			end
			for (i = 0; i < NB; i = i + 1)
			begin
				if (wr && idx == fn_idx(`MMT_OFS_MODE_B) + i[5:0])
					b_mode_ff[i] <= pwdata[`MMT_BM_EVT];
				if (wr && idx == fn_idx(`MMT_OFS_COUNT_B) + i[5:0])
				begin
					b_rel_ff[i] <= pwdata[15:0];
					if (!run_bit_b[i])
						b_cnt_ff[i] <= pwdata[15:0];
				end
				if (!run_bit_b[i] && nxt_run_b[i])
					b_cnt_ff[i] <= b_rel_ff[i];
				else if (b_rld[i])
					b_cnt_ff[i] <= b_rel_ff[i];
				else if (b_ev[i])
					b_cnt_ff[i] <= fn_dec(b_cnt_ff[i]);
			end
		end
	end
endmodule

// ### tb/mmt_timer_properties.sv
`include "mmt_regs_regs.vh"
module mmt_timer_properties (
	input logic        mclk,
	input logic        sys_rst,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic [4:0]  pulse_output_a,
	input logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       run_ff;
	logic [1:0] mode_ff;
	logic       mask_ff;
	wire        wr = psel && penable && pwrite;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// shadow of channel 0 setup, seen only through bus writes
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			run_ff <= 1'b0;
			mode_ff <= 2'h0;
			mask_ff <= 1'b0;
		end
		else if (wr)
		begin
			if (paddr == `MMT_OFS_START_A)
				run_ff <= pwdata[0];
			if (paddr == `MMT_OFS_MODE_A)
				mode_ff <= pwdata[1:0];
			if (paddr == `MMT_OFS_IRQ_MASK)
				mask_ff <= pwdata[0];
		end
	end

	rst_idle_a: assert property ($fell(sys_rst) |->
		pulse_output_a == 5'h00 && !irq && prdata == 32'h0)
		else $error("outputs busy after reset");
	out_run_a: assert property ($rose(pulse_output_a[0]) |-> run_ff)
		else $error("output rose on stopped channel");
	stop_low_a: assert property (wr && paddr == `MMT_OFS_START_A
		&& !pwdata[0] && run_ff && mode_ff[1] |-> ##[1:2] !pulse_output_a[0])
		else $error("output high after stop");
	os_irq_a: assert property (wr && paddr == `MMT_OFS_START_A
		&& !pwdata[0] && run_ff && mode_ff == 2'h2 && mask_ff |-> ##[1:3] irq)
		else $error("no request after one-shot stop");
	mode_irq_a: assert property (wr && paddr == `MMT_OFS_MODE_A
		&& !mode_ff[1] && pwdata[1] && mask_ff |=> irq)
		else $error("no request after mode change");
	mask_off_a: assert property (wr && paddr == `MMT_OFS_IRQ_MASK
		&& pwdata[10:0] == 11'h000 |=> !irq)
		else $error("irq with all masked");
	ready_now_a: assert property (psel && penable |-> pready)
		else $error("wait state inserted");
	err_data_a: assert property (psel && penable && !pwrite && pslverr
		|-> prdata == 32'h0)
		else $error("data on refused read");
endmodule

bind mmt_timer mmt_timer_properties chk_i (.mclk, .sys_rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.pulse_output_a, .irq);

// ### tb/multimode_timer_ab_tb.sv
`include "mmt_regs_regs.vh"
module multimode_timer_ab_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        irq;
	logic [4:0]  pulse_output_a;
	logic [4:0]  event_in_a = 5'h00;
	logic [4:0]  trigger_input_a = 5'h00;
	logic [5:0]  event_in_b = 6'h00;
	int          bad_count = 0;
	int          checked = 0;
	logic [7:0]  ra [6] = '{`MMT_OFS_COUNT_A, `MMT_OFS_COUNT_A + 8'h10,
		`MMT_OFS_COUNT_B, `MMT_OFS_COUNT_B + 8'h14,
		`MMT_OFS_COUNT_A + 8'h08, `MMT_OFS_COUNT_B + 8'h0c};
	logic [15:0] rv [6] = '{16'h1234, 16'hffff, 16'h0001, 16'h8000,
		16'h00ff, 16'ha5a5};

	// short prescale keeps every run well inside the watchdog
	mmt_timer #(.PRESCALE(2)) DUT (.mclk(mclk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_in_a(event_in_a),
		.trigger_input_a(trigger_input_a), .event_in_b(event_in_b),
		.pulse_output_a(pulse_output_a), .irq(irq));

	always #5 mclk = ~mclk;

	task end_sim;
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	// one apb transfer; read data and error taken at the ready edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// read whose setup edge meets one rising event on channel a1
	task ev_rd(input logic [7:0] a);
		fork
			xfer(1'b0, a, 32'h0);
			begin
				@(posedge mclk);
				event_in_a <= 5'h02;
				@(posedge mclk);
				event_in_a <= 5'h00;
			end
		join
	endtask

	// falling edges, so registered outputs have settled
	task wt(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// main sequence: table rows first, then the awkward cases
	initial
	begin
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			xfer(1'b1, ra[i], {16'h0, rv[i]});
			xfer(1'b0, ra[i], 32'h0);
			chk(rd, {16'h0, rv[i]});
		end
		wt(20);
		xfer(1'b0, `MMT_OFS_COUNT_A, 32'h0);
		chk(rd, {16'h0, rv[0]});
		xfer(1'b1, `MMT_OFS_COUNT_A, 32'h10);
		xfer(1'b1, `MMT_OFS_START_A, 32'h1);
		wt(10);
		xfer(1'b0, `MMT_OFS_COUNT_A, 32'h0);
		chk(rd[15:0] < 16'h0010, 1);
		xfer(1'b1, `MMT_OFS_START_A, 32'h0);
		xfer(1'b1, `MMT_OFS_COUNT_B + 8'h08, 32'h30);
		xfer(1'b1, `MMT_OFS_START_B, 32'h4);
		wt(10);
		xfer(1'b0, `MMT_OFS_COUNT_B + 8'h08, 32'h0);
		chk(rd[15:0] < 16'h0030, 1);
		xfer(1'b1, `MMT_OFS_START_B, 32'h0);
		// unmapped word is refused and reads zero
		xfer(1'b0, 8'hfc, 32'h0);
		chk(err, 1);
		chk(rd, 0);
		xfer(1'b1, `MMT_OFS_IRQ_MASK, 32'h1);
		xfer(1'b1, `MMT_OFS_MODE_A, 32'h2);
		wt(1);
		chk(irq, 1);
		xfer(1'b1, `MMT_OFS_IRQ_STAT, 32'h7ff);
		wt(1);
		chk(irq, 0);
		xfer(1'b1, `MMT_OFS_MODE_A, 32'h0);
		xfer(1'b1, `MMT_OFS_MODE_A, 32'h3);
		wt(1);
		chk(irq, 1);
		xfer(1'b1, `MMT_OFS_IRQ_MASK, 32'h0);
		wt(1);
		chk(irq, 0);
		// one-shot: trigger, then stop while the pulse is high
		xfer(1'b1, `MMT_OFS_IRQ_MASK, 32'h1);
		xfer(1'b1, `MMT_OFS_MODE_A, 32'h2);
		xfer(1'b1, `MMT_OFS_IRQ_STAT, 32'h7ff);
		xfer(1'b1, `MMT_OFS_COUNT_A, 32'h20);
		xfer(1'b1, `MMT_OFS_START_A, 32'h1);
		xfer(1'b1, `MMT_OFS_OS_TRIG, 32'h1);
		wt(6);
		chk(pulse_output_a[0], 1);
		xfer(1'b1, `MMT_OFS_START_A, 32'h0);
		wt(3);
		chk(pulse_output_a[0], 0);
		chk(irq, 1);
		xfer(1'b0, `MMT_OFS_COUNT_A, 32'h0);
		chk(rd, 32'h20);
		// pwm stopped during the high phase
		xfer(1'b1, `MMT_OFS_MODE_A, 32'h3);
		xfer(1'b1, `MMT_OFS_IRQ_STAT, 32'h7ff);
		xfer(1'b1, `MMT_OFS_COUNT_A, 32'h40);
		xfer(1'b1, `MMT_OFS_START_A, 32'h1);
		wt(10);
		chk(pulse_output_a[0], 1);
		xfer(1'b1, `MMT_OFS_START_A, 32'h0);
		wt(2);
		chk(pulse_output_a[0], 0);
		chk(irq, 1);
		// pwm stopped during the low phase leaves pin and flag alone
		xfer(1'b1, `MMT_OFS_COUNT_A, 32'h1);
		xfer(1'b1, `MMT_OFS_START_A, 32'h1);
		wt(20);
		chk(pulse_output_a[0], 0);
		xfer(1'b1, `MMT_OFS_IRQ_STAT, 32'h7ff);
		xfer(1'b1, `MMT_OFS_START_A, 32'h0);
		wt(2);
		chk(pulse_output_a[0], 0);
		chk(irq, 0);
		// external trigger, then a software retrigger mid-pulse
		xfer(1'b1, `MMT_OFS_MODE_A, 32'ha);
		xfer(1'b1, `MMT_OFS_COUNT_A, 32'h10);
		xfer(1'b1, `MMT_OFS_START_A, 32'h1);
		@(posedge mclk);
		trigger_input_a <= 5'h01;
		@(posedge mclk);
		trigger_input_a <= 5'h00;
		wt(4);
		chk(pulse_output_a[0], 1);
		xfer(1'b1, `MMT_OFS_OS_TRIG, 32'h1);
		wt(34);
		chk(pulse_output_a[0], 1);
		wt(10);
		chk(pulse_output_a[0], 0);
		// event counting on channel a1: reads that meet a reload
		xfer(1'b1, `MMT_OFS_MODE_A + 8'h04, 32'h1);
		xfer(1'b1, `MMT_OFS_COUNT_A + 8'h04, 32'h0);
		xfer(1'b1, `MMT_OFS_START_A, 32'h2);
		ev_rd(`MMT_OFS_COUNT_A + 8'h04);
		chk(rd, {16'h0, `MMT_RD_RELOAD});
		xfer(1'b1, `MMT_OFS_START_A, 32'h0);
		xfer(1'b1, `MMT_OFS_MODE_A + 8'h04, 32'h5);
		xfer(1'b1, `MMT_OFS_COUNT_A + 8'h04, 32'hffff);
		xfer(1'b1, `MMT_OFS_START_A, 32'h2);
		ev_rd(`MMT_OFS_COUNT_A + 8'h04);
		chk(rd, {16'h0, `MMT_RD_OVF});
		xfer(1'b0, `MMT_OFS_COUNT_A + 8'h04, 32'h0);
		chk(rd, 32'hffff);
		// b0 counts events; its run bit sits in the a start register
		xfer(1'b1, `MMT_OFS_START_A, 32'h0);
		xfer(1'b1, `MMT_OFS_MODE_B, 32'h1);
		xfer(1'b1, `MMT_OFS_COUNT_B, 32'h3);
		xfer(1'b1, `MMT_OFS_START_A, 32'h20);
		xfer(1'b0, `MMT_OFS_START_A, 32'h0);
		chk(rd, 32'h20);
		repeat (2)
		begin
			@(posedge mclk);
			event_in_b <= 6'h01;
			@(posedge mclk);
			event_in_b <= 6'h00;
		end
		xfer(1'b0, `MMT_OFS_COUNT_B, 32'h0);
		chk(rd, 32'h1);
		// reset in mid-run: everything idle again
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		xfer(1'b0, `MMT_OFS_START_A, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, `MMT_OFS_COUNT_B, 32'h0);
		chk(rd, {16'h0, `MMT_RST_CNT});
		chk({irq, pulse_output_a}, 6'h00);
		end_sim;
	end

	// watchdog, far beyond the few hundred cycles needed
	initial
	begin
		#200000;
		bad_count++;
		end_sim;
	end
endmodule
